// *** rtl/fmao_consts.svh ***
// Fault monitor constants: register offsets, field positions, reset values, timing
// Assumes APB byte addressing, one 32-bit word per register
`ifndef FMAO_CONSTS_SVH
`define FMAO_CONSTS_SVH

`define FMAO_OFF_PRIMARY      12'h000
`define FMAO_OFF_PRIMARY_EN   12'h004
`define FMAO_OFF_SECONDARY    12'h008
`define FMAO_OFF_SECONDARY_EN 12'h00c
`define FMAO_OFF_WIRE_BREAK   12'h010
`define FMAO_OFF_AUX_CTRL     12'h014
`define FMAO_OFF_LED          12'h018
`define FMAO_OFF_CONFIG       12'h01c
`define FMAO_OFF_STATUS       12'h020

// Primary flag bit positions
`define FMAO_P_SUP_LOW   0
`define FMAO_P_SUP_MISS  1
`define FMAO_P_TEMP1     2
`define FMAO_P_TEMP2     3
`define FMAO_P_CRC       4
`define FMAO_P_POR       5
`define FMAO_P_WBG       6
`define FMAO_P_SEC       7

// Secondary flag bit positions
`define FMAO_S_IREF_SHORT 0
`define FMAO_S_IREF_OPEN  1
`define FMAO_S_WREF_SHORT 2
`define FMAO_S_WREF_OPEN  3
`define FMAO_S_SHUTDOWN   4

// Aux control fields
`define FMAO_A_DIR 6
`define FMAO_A_STK 7

`define FMAO_PRIMARY_EN_RST 8'h30
`define FMAO_SECONDARY_EN_RST 5'h00
`define FMAO_AUX_CTRL_RST 8'h00

// Timing: clock and minimum fault pulse, LED scan
`define FMAO_CLK_KHZ      50000
`define FMAO_MIN_PULSE_NS 1000
`define FMAO_MIN_PULSE_CYC ((`FMAO_MIN_PULSE_NS * `FMAO_CLK_KHZ + 999999) / 1000000)
`define FMAO_LED_HZ       1000
`define FMAO_LED_PERIOD_CYC (`FMAO_CLK_KHZ * 1000 / `FMAO_LED_HZ)
`define FMAO_LED_SLOT_CYC (`FMAO_LED_PERIOD_CYC / 3)

`endif

// *** rtl/fmao_pkg.sv ***
// Types shared by the fault monitor modules
// Assumes fmao_consts.svh supplies the numbers
package fmao_pkg;
  typedef logic [7:0] fmao_byte_t;
  typedef enum logic [1:0] {
    FMAO_COL0 = 2'b00,
    FMAO_COL1 = 2'b01,
    FMAO_COL2 = 2'b10
  } fmao_col_t;
endpackage

// *** rtl/fmao_aux_if.sv ***
// Carrier between the fault core and the aux pin driver
// Assumes both ends on pclk
`timescale 1ns/1ps
interface fmao_aux_if;
  logic       direct_mode;
  logic [5:0] direct_level;
  logic [8:0] led_on;
  logic [5:0] pin_out;
  logic [5:0] pin_oe;
  modport core (output direct_mode, output direct_level, output led_on,
                input pin_out, input pin_oe);
  modport drv  (input direct_mode, input direct_level, input led_on,
                output pin_out, output pin_oe);
endinterface

// *** rtl/fmao_pulse_stretch.sv ***
// Stretches the fault request to a minimum low time on the open-drain pin
// Assumes request synchronous to pclk
`timescale 1ns/1ps
`include "fmao_consts.svh"
module fmao_pulse_stretch import fmao_pkg::*; #(
  parameter int unsigned MIN_CYC = `FMAO_MIN_PULSE_CYC
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request and stretched output
  input  wire logic req,
  output logic      active
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        act;
  } fmao_ps_state_t;
  fmao_ps_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (req && !s_q.act) begin
      s_d.act = 1'b1;
      s_d.cnt = 16'(MIN_CYC - 1);
    end else if (s_q.act) begin
      if (s_q.cnt != 16'h0000) begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end else if (!req) begin
        s_d.act = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Low held at least 1 us
  assign active = s_q.act;
endmodule

// *** rtl/fmao_aux_drive.sv ***
// Drives six row and column pins as LED matrix or direct outputs
// Assumes rows pull cathodes low and columns source anodes
`timescale 1ns/1ps
`include "fmao_consts.svh"
module fmao_aux_drive import fmao_pkg::*; #(
  parameter int unsigned SLOT_CYC = `FMAO_LED_SLOT_CYC
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Core side
  fmao_aux_if.drv   aux
);
  typedef struct packed {
    logic [15:0] cnt;
    fmao_col_t   col;
    logic [5:0]  out;
    logic [5:0]  oe;
  } fmao_ad_state_t;
  fmao_ad_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (aux.direct_mode) begin
      s_d.cnt = '0;
      s_d.col = FMAO_COL0;
      s_d.out = aux.direct_level;
      s_d.oe  = 6'h3f;
    end else begin
      if (s_q.cnt == 16'(SLOT_CYC - 1)) begin
        s_d.cnt = '0;
        unique case (s_q.col)
          FMAO_COL0: s_d.col = FMAO_COL1;
          FMAO_COL1: s_d.col = FMAO_COL2;
          FMAO_COL2: s_d.col = FMAO_COL0;
          default:   s_d.col = FMAO_COL0;
        endcase
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
      // One row at a time, so each column resistor feeds one LED
      // LED bits pick columns; pins[2:0] rows, pins[5:3] columns
      // Scan index names the active row, pulled low
      s_d.out = 6'h00;
      s_d.oe  = 6'h00;
      for (int c = 0; c < 3; c++) begin
        if (aux.led_on[int'(s_q.col)*3 + c]) begin
          s_d.out[3 + c] = 1'b1;
          s_d.oe[3 + c]  = 1'b1;
        end
      end
      s_d.oe[int'(s_q.col)] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign aux.pin_out = s_q.out;
  assign aux.pin_oe  = s_q.oe;
endmodule

// *** rtl/fmao_fault_monitor.sv ***
// Fault flag collection, enables, open-drain fault pin and aux pins with APB
// Assumes fault causes are synchronous levels; read strobes come via APB
`timescale 1ns/1ps
`include "fmao_consts.svh"
module fmao_fault_monitor import fmao_pkg::*; #(
  parameter int unsigned MIN_CYC  = `FMAO_MIN_PULSE_CYC,
  parameter int unsigned SLOT_CYC = `FMAO_LED_SLOT_CYC
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Fault causes (levels)
  input  wire logic        supply_low_cause,
  input  wire logic        supply_missing_cause,
  input  wire logic        temp_one_cause,
  input  wire logic        temp_two_cause,
  input  wire logic        shutdown_cause,
  input  wire logic [7:0]  wire_break_cause,
  input  wire logic        external_monitor_input,
  input  wire logic        iref_short_cause,
  input  wire logic        iref_open_cause,
  input  wire logic        wref_short_cause,
  input  wire logic        wref_open_cause,
  // Serial frame events (pulses)
  input  wire logic        frame_bad,
  input  wire logic        frame_good_checked,
  // Block controls
  output logic             channels_enable,
  output logic             field_blocks_enable,
  // Fault pin, open drain
  output logic             field_fault_out_n,
  output logic             field_fault_oe,
  // Matrix pins
  output logic [2:0]       matrix_row_pin,
  output logic [2:0]       matrix_row_oe,
  output logic [2:0]       matrix_column_pin,
  output logic [2:0]       matrix_column_oe
);
  typedef struct packed {
    fmao_byte_t primary_en;
    logic [4:0] secondary_en;
    logic       sup_low;
    logic       sup_miss;
    logic       temp1;
    logic       temp2;
    logic       crc;
    logic       por;
    logic [7:0] wb;
    logic [4:0] sec;
    fmao_byte_t aux_ctrl;
    logic [7:0] led;
    logic       clear_sel;
    logic [7:0] wb_detect_en;
    logic       ack;
    logic [31:0] rdata;
  } fmao_state_t;
  fmao_state_t s_q, s_d;

  fmao_aux_if aux ();

  function automatic logic [31:0] fmao_word(input logic [7:0] b);
    fmao_word = {24'h000000, b};
  endfunction

  logic        access;
  logic        rd;
  logic        wr;
  logic        rd_primary;
  logic        rd_wb;
  logic        addr_ok;
  logic        mon_on;
  logic [7:0]  wb_eff;
  logic [4:0]  sec_cause;
  logic [7:0]  prim_flags;
  logic [7:0]  prim_live;
  logic [7:0]  prim_pin;
  logic        fault_req;
  logic        fault_active;

  assign access = psel && penable;
  // One wait state: read data is captured on the first access edge and
  // stands while pready is high; read clears happen at capture, so a flag
  // set after the capture survives
  assign rd     = access && !pwrite && !s_q.ack;
  assign wr     = access && pwrite && s_q.ack;
  assign pready = access && s_q.ack;
  assign addr_ok = (paddr == `FMAO_OFF_PRIMARY) || (paddr == `FMAO_OFF_PRIMARY_EN) ||
                   (paddr == `FMAO_OFF_SECONDARY) || (paddr == `FMAO_OFF_SECONDARY_EN) ||
                   (paddr == `FMAO_OFF_WIRE_BREAK) || (paddr == `FMAO_OFF_AUX_CTRL) ||
                   (paddr == `FMAO_OFF_LED) || (paddr == `FMAO_OFF_CONFIG) ||
                   (paddr == `FMAO_OFF_STATUS);
  assign pslverr = pready && !addr_ok;
  assign rd_primary = rd && (paddr == `FMAO_OFF_PRIMARY);
  assign rd_wb      = rd && (paddr == `FMAO_OFF_WIRE_BREAK);

  assign mon_on = !external_monitor_input;

  always_comb begin
    wb_eff = wire_break_cause & s_q.wb_detect_en;
    if (wref_short_cause) begin
      wb_eff = s_q.wb_detect_en;
    end else if (wref_open_cause) begin
      wb_eff = 8'h00;
    end
  end

  // Open flag when all detection off
  assign sec_cause = {shutdown_cause,
                      wref_open_cause || (s_q.wb_detect_en == 8'h00),
                      wref_short_cause, iref_open_cause, iref_short_cause};

  // Shutdown stops field blocks, registers kept
  assign channels_enable     = !iref_short_cause && !shutdown_cause;
  assign field_blocks_enable = !shutdown_cause;

  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h00000000;
    s_d.ack   = access && !s_q.ack;
    // Latched supply and temp flags, set wins over clear
    if (rd_primary || (frame_good_checked && !s_q.clear_sel)) begin
      s_d.sup_low  = 1'b0;
      s_d.sup_miss = 1'b0;
    end
    if (rd_primary) begin
      s_d.temp1 = 1'b0;
      s_d.temp2 = 1'b0;
      s_d.por   = 1'b0;
      s_d.sec   = 5'h00;
    end
    if (supply_low_cause && mon_on) begin
      s_d.sup_low = 1'b1;
    end
    if (supply_missing_cause && mon_on) begin
      s_d.sup_miss = 1'b1;
    end
    if (!mon_on) begin
      s_d.sup_low  = 1'b0;
      s_d.sup_miss = 1'b0;
    end
    s_d.temp1 = s_d.temp1 | temp_one_cause;
    s_d.temp2 = s_d.temp2 | temp_two_cause;
    s_d.sec   = s_d.sec | sec_cause;
    // Frame flag held until good frame
    if (frame_bad) begin
      s_d.crc = 1'b1;
    end else if (frame_good_checked) begin
      s_d.crc = 1'b0;
    end
    s_d.wb = (rd_wb ? 8'h00 : s_q.wb) | wb_eff;
    if (wr) begin
      unique case (paddr)
        `FMAO_OFF_PRIMARY_EN:   s_d.primary_en   = pwdata[7:0];
        `FMAO_OFF_SECONDARY_EN: s_d.secondary_en = pwdata[4:0];
        `FMAO_OFF_AUX_CTRL:     s_d.aux_ctrl     = pwdata[7:0];
        `FMAO_OFF_LED:          s_d.led          = pwdata[7:0];
        `FMAO_OFF_CONFIG: begin
          s_d.clear_sel    = pwdata[0];
          s_d.wb_detect_en = pwdata[15:8];
        end
        default: s_d = s_d;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        `FMAO_OFF_PRIMARY:      s_d.rdata = fmao_word(prim_flags);
        `FMAO_OFF_PRIMARY_EN:   s_d.rdata = fmao_word(s_q.primary_en);
        `FMAO_OFF_SECONDARY:    s_d.rdata = fmao_word({3'h0, s_q.sec});
        `FMAO_OFF_SECONDARY_EN: s_d.rdata = fmao_word({3'h0, s_q.secondary_en});
        `FMAO_OFF_WIRE_BREAK:   s_d.rdata = fmao_word(s_q.wb);
        `FMAO_OFF_AUX_CTRL:     s_d.rdata = fmao_word(s_q.aux_ctrl);
        `FMAO_OFF_LED:          s_d.rdata = fmao_word(s_q.led);
        `FMAO_OFF_CONFIG:       s_d.rdata = {16'h0000, s_q.wb_detect_en, 7'h00, s_q.clear_sel};
        `FMAO_OFF_STATUS:       s_d.rdata = {30'h0, fault_active, fault_req};
        default:                s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // Group flag is OR of latched wire-break flags
  // Summary bit shows any secondary flag; enables only reach the pin
  assign prim_flags = {|s_q.sec, |s_q.wb, s_q.por, s_q.crc,
                       s_q.temp2, s_q.temp1, s_q.sup_miss, s_q.sup_low};
  assign prim_pin   = {|(s_q.sec & s_q.secondary_en), prim_flags[6:0]};
  // Live causes and the latched frame flag used when the pin is not sticky
  assign prim_live = {|(sec_cause & s_q.secondary_en), |wb_eff, 1'b0, s_q.crc,
                      temp_two_cause, temp_one_cause,
                      supply_missing_cause && mon_on, supply_low_cause && mon_on};

  // Sticky follows latched flag
  // Power-on event has no live cause, so it always uses its flag
  assign fault_req = s_q.aux_ctrl[`FMAO_A_STK] ? |(prim_pin & s_q.primary_en)
                   : (|(prim_live & s_q.primary_en) || (s_q.por && s_q.primary_en[`FMAO_P_POR]));

  fmao_pulse_stretch #(
    .MIN_CYC (MIN_CYC)
  ) u_stretch (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (fault_req),
    .active  (fault_active)
  );

  assign field_fault_out_n = 1'b0;
  assign field_fault_oe    = fault_active;

  assign aux.direct_mode  = s_q.aux_ctrl[`FMAO_A_DIR];
  assign aux.direct_level = s_q.aux_ctrl[5:0];
  assign aux.led_on       = {s_q.led[7:4], !supply_missing_cause, s_q.led[3:0]};

  fmao_aux_drive #(
    .SLOT_CYC (SLOT_CYC)
  ) u_aux (
    .pclk    (pclk),
    .presetn (presetn),
    .aux     (aux.drv)
  );

  assign matrix_row_pin    = aux.pin_out[2:0];
  assign matrix_row_oe     = aux.pin_oe[2:0];
  assign matrix_column_pin = aux.pin_out[5:3];
  assign matrix_column_oe  = aux.pin_oe[5:3];
  assign prdata            = s_q.rdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q              <= '0;
      s_q.primary_en   <= `FMAO_PRIMARY_EN_RST;
      s_q.secondary_en <= `FMAO_SECONDARY_EN_RST;
      s_q.aux_ctrl     <= `FMAO_AUX_CTRL_RST;
      s_q.por          <= 1'b1;
      s_q.sec          <= 5'h08;
      s_q.wb_detect_en <= 8'hff;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// *** tb/fmao_fault_monitor_asserts.sv ***
// Checker on the fault monitor top ports
// Assumes bind from the bench top, one pclk domain
`timescale 1ns/1ps
module fmao_fault_monitor_asserts #(
  parameter int unsigned MIN_CYC = 4
) (
  // Clock, reset, APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Causes and controls
  input wire logic        shutdown_cause,
  input wire logic        iref_short_cause,
  input wire logic        channels_enable,
  input wire logic        field_blocks_enable,
  // Pins
  input wire logic        field_fault_out_n,
  input wire logic        field_fault_oe,
  input wire logic [2:0]  matrix_row_pin,
  input wire logic [2:0]  matrix_row_oe,
  input wire logic [2:0]  matrix_column_pin,
  input wire logic [2:0]  matrix_column_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] hi_q, hi_d;
  logic [1:0] cyc_q, cyc_d;
  logic       dir_q, dir_d;
  always_comb begin
    hi_d  = field_fault_oe ? ((hi_q == 8'hff) ? hi_q : hi_q + 8'h01) : 8'h00;
    cyc_d = (cyc_q == 2'h3) ? cyc_q : cyc_q + 2'h1;
    dir_d = dir_q;
    if (psel && penable && pready && pwrite && paddr == 12'h014) begin
      dir_d = pwdata[6];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q  <= 8'h00;
      cyc_q <= 2'h0;
      dir_q <= 1'b0;
    end else begin
      hi_q  <= hi_d;
      cyc_q <= cyc_d;
      dir_q <= dir_d;
    end
  end
  sequence aux_dir_wr_s;
    psel && penable && pready && pwrite && paddr == 12'h014 && pwdata[6];
  endsequence
  sequence bad_access_s;
    psel && penable && paddr > 12'h020;
  endsequence
  pulse_min_a: assert property ($fell(field_fault_oe) |-> hi_q >= MIN_CYC)
    else $error("fault pin low time too short");
  pin_low_only_a: assert property (field_fault_out_n == 1'b0)
    else $error("fault pin drives high");
  direct_oe_a: assert property (aux_dir_wr_s |-> ##2 (&matrix_row_oe) && (&matrix_column_oe))
    else $error("direct mode pins not driven");
  direct_lvl_a: assert property (aux_dir_wr_s |-> ##2
    {matrix_column_pin, matrix_row_pin} == $past(pwdata[5:0], 2))
    else $error("direct mode level wrong");
  scan_one_row_a: assert property (!dir_q && !$past(dir_q) && !$past(dir_q, 2) |->
    $onehot0(matrix_row_oe))
    else $error("more than one row driven");
  por_fault_a: assert property (cyc_q == 2'h2 |-> field_fault_oe ##1 field_fault_oe)
    else $error("power-on fault not shown");
  shut_off_a: assert property (shutdown_cause |-> !field_blocks_enable && !channels_enable)
    else $error("blocks on in shutdown");
  iref_off_a: assert property (iref_short_cause |-> !channels_enable)
    else $error("inputs on with reference short");
  unmapped_err_a: assert property (bad_access_s |-> ##[0:1] (pready && pslverr))
    else $error("unmapped access not refused");
endmodule

// *** tb/fmao_host_model.sv ***
// Host model watching the open-drain fault line
// Assumes a pull-up on the line and one pclk domain
`timescale 1ns/1ps
module fmao_host_model #(
  parameter int unsigned MIN_CYC = 4
) (
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Fault pin
  input  wire logic   field_fault_out_n,
  input  wire logic   field_fault_oe,
  // What the host sees
  output logic        fault_line_n,
  output int unsigned short_cnt
);
  int unsigned width;
  assign fault_line_n = field_fault_oe ? field_fault_out_n : 1'b1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width = 0;
      short_cnt = 0;
    end else if (fault_line_n === 1'b0) begin
      width++;
    end else begin
      if (width != 0 && width < MIN_CYC) short_cnt++;
      width = 0;
    end
  end
endmodule

// *** tb/tb_fault_monitor_and_aux_outputs.sv ***
// Self-checking bench for the fault monitor block
// Assumes shortened pulse and scan counts, APB master here
`timescale 1ns/1ps
`include "fmao_consts.svh"
module tb_fault_monitor_and_aux_outputs;
  localparam int unsigned MIN_CYC = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  cz, rc;
  logic [7:0]  wire_break_cause, wb;
  logic        shutdown_cause, external_monitor_input, frame_bad, frame_good_checked;
  logic        channels_enable, field_blocks_enable, field_fault_out_n, field_fault_oe;
  logic [2:0]  matrix_row_pin, matrix_row_oe, matrix_column_pin, matrix_column_oe;
  logic        fault_line_n;
  int unsigned short_cnt;
  int          num_errors, n_tests, i, b, en, n;

  fmao_fault_monitor #(.MIN_CYC(MIN_CYC), .SLOT_CYC(8)) DUT (.*,
    .supply_low_cause(cz[0]), .supply_missing_cause(cz[1]), .temp_one_cause(cz[2]),
    .temp_two_cause(cz[3]), .iref_short_cause(rc[0]), .iref_open_cause(rc[1]),
    .wref_short_cause(rc[2]), .wref_open_cause(rc[3]));
  fmao_host_model #(.MIN_CYC(MIN_CYC)) host (.*);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] pins_exp(input int v);
    return {20'h0, 6'h3f, v[5:0]};
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (k >= 100) begin
      num_errors++;
      $display("[ERR] %0t apb wait", $time);
      end_sim();
    end
    q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cz, rc} = '0;
    {wire_break_cause, shutdown_cause, external_monitor_input} = '0;
    {frame_bad, frame_good_checked, num_errors, n_tests} = '0;
    i = $urandom(32'h76f3);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    #1;
    chk(field_fault_oe, 1'b1, "por pin");
    apb(0, `FMAO_OFF_PRIMARY_EN, 0);
    chk(q, 32'h30, "enable reset");
    apb(0, `FMAO_OFF_AUX_CTRL, 0);
    chk(q, 32'h0, "aux reset");
    apb(0, `FMAO_OFF_PRIMARY, 0);
    chk(q, 32'ha0, "reset flags");
    repeat (MIN_CYC + 3) @(posedge pclk);
    #1;
    chk(field_fault_oe, 1'b0, "pin idle");
    for (i = 0; i < 8; i++) begin
      b  = i % 4;
      en = (i == 1 || i == 5) ? 1 : $urandom % 2;
      apb(1, `FMAO_OFF_AUX_CTRL, (i / 4) << 7);
      apb(1, `FMAO_OFF_PRIMARY_EN, en << b);
      cz[b] <= 1'b1;
      repeat (2 + $urandom % 3) @(posedge pclk);
      cz[b] <= 1'b0;
      #1;
      chk(field_fault_oe, en[0], "pin set");
      repeat (10) @(posedge pclk);
      #1;
      chk(field_fault_oe, en[0] & (i >= 4), "pin after cause");
      apb(0, `FMAO_OFF_PRIMARY, 0);
      chk(q[b], 1'b1, "flag latched");
      repeat (MIN_CYC + 3) @(posedge pclk);
      #1;
      chk(field_fault_oe, 1'b0, "pin after read");
      apb(0, `FMAO_OFF_PRIMARY, 0);
      chk(q[b], 1'b0, "flag cleared");
    end
    apb(1, `FMAO_OFF_PRIMARY_EN, 0);
    external_monitor_input <= 1'b1;
    cz <= 4'h3;
    repeat (3) @(posedge pclk);
    cz <= 4'h0;
    apb(0, `FMAO_OFF_PRIMARY, 0);
    chk(q[1:0], 2'b00, "supply flags off");
    external_monitor_input <= 1'b0;
    wb = 8'($urandom % 255 + 1);
    wire_break_cause <= wb;
    @(posedge pclk);
    wire_break_cause <= 8'h00;
    repeat (3) @(posedge pclk);
    apb(0, `FMAO_OFF_PRIMARY, 0);
    chk(q[6], 1'b1, "group set");
    apb(0, `FMAO_OFF_PRIMARY, 0);
    chk(q[6], 1'b1, "group kept");
    apb(0, `FMAO_OFF_WIRE_BREAK, 0);
    chk(q, {24'h0, wb}, "wire flags");
    apb(0, `FMAO_OFF_PRIMARY, 0);
    chk(q[6], 1'b0, "group clear");
    frame_bad <= 1'b1;
    @(posedge pclk);
    frame_bad <= 1'b0;
    apb(0, `FMAO_OFF_PRIMARY, 0);
    apb(0, `FMAO_OFF_PRIMARY, 0);
    chk(q[4], 1'b1, "frame error held");
    cz <= 4'h2;
    @(posedge pclk);
    cz <= 4'h0;
    frame_good_checked <= 1'b1;
    @(posedge pclk);
    frame_good_checked <= 1'b0;
    apb(0, `FMAO_OFF_PRIMARY, 0);
    chk(q[4:0], 5'h00, "good frame clears");
    for (i = 0; i < 4; i++) begin
      rc <= 4'h1 << i;
      repeat (3) @(posedge pclk);
      #1;
      if (i == 0) chk(channels_enable, 1'b0, "inputs off");
      rc <= 4'h0;
      apb(0, `FMAO_OFF_SECONDARY, 0);
      chk(q[i], 1'b1, "reference flag");
      apb(0, `FMAO_OFF_WIRE_BREAK, 0);
      if (i == 2) chk(q, 32'hff, "breaks forced on");
    end
    shutdown_cause <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk({channels_enable, field_blocks_enable}, 2'b00, "shutdown");
    shutdown_cause <= 1'b0;
    apb(0, `FMAO_OFF_SECONDARY, 0);
    chk(q[4], 1'b1, "shutdown flag");
    apb(0, `FMAO_OFF_AUX_CTRL, 0);
    chk(q, 32'h80, "registers kept");
    apb(0, `FMAO_OFF_PRIMARY, 0);
    apb(1, `FMAO_OFF_CONFIG, 0);
    repeat (2) @(posedge pclk);
    apb(0, `FMAO_OFF_SECONDARY, 0);
    chk(q[3], 1'b1, "detect off flag");
    for (i = 0; i < 4; i++) begin
      b = (i == 0) ? 0 : (i == 1) ? 63 : $urandom % 64;
      apb(1, `FMAO_OFF_AUX_CTRL, 32'h40 | b);
      repeat (2) @(posedge pclk);
      #1;
      chk({matrix_column_oe, matrix_row_oe, matrix_column_pin, matrix_row_pin},
          pins_exp(b), "direct pins");
    end
    apb(1, `FMAO_OFF_AUX_CTRL, 0);
    apb(1, `FMAO_OFF_LED, 32'hff);
    repeat (2) @(posedge pclk);
    n = 0;
    b = 0;
    repeat (60) begin
      @(posedge pclk);
      if (matrix_row_oe === 3'b001) n++;
      if (matrix_column_oe !== 3'b111) b++;
    end
    chk(n >= 16 && n <= 24, 1'b1, "row duty");
    chk(b, 0, "columns lit");
    apb(1, 12'h024, 32'hffffffff);
    chk(err_q, 1'b1, "unmapped write");
    apb(0, 12'h024, 0);
    chk(q, 32'h0, "unmapped read");
    chk(short_cnt, 0, "short pulse");
    end_sim();
  end
endmodule

bind fmao_fault_monitor fmao_fault_monitor_asserts #(.MIN_CYC(MIN_CYC)) u_chk (.*);
